// *** ext_bus_arb.sv ***
// external bus controller arbitration: idle cycles, bus release, master priority
// assumes: one clock pclk, apb register access, masters on pclk, pins synchronised here
//
// Contract
// - idle cycle is exactly one state
// - area change between reads inserts idle
// - area change idle only in advanced mode
// - write after read inserts idle
// - idle insertion enabled after reset
// - release needs expansion mode and enable bit
// - request low grants and floats bus
// - external access waits while bus released
// - request high ends release, grant high
// - release request beats external access
// - all-stopped values in sleep halt release
// - highest requester acknowledged, keeps until withdrawn
// - transfer controller beats the cpu
// - internal access runs during release
// - cpu yields only between bus cycles
// - sleeping cpu yields at once
// - activation raises transfer controller request
// - transfer controller yields only after operations
// - release only after current external cycle
// - power-on reset aborts cycle at once
// - manual reset keeps state, completes cycle
`include "ext_bus_arb_cfg.svh"

module ext_bus_arb (
  // clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal masters
  input wire ext_bus_arb_pkg::mreq_s cpu_req,
  input wire ext_bus_arb_pkg::mreq_s xfer_req,
  input wire logic cpu_sleep,
  output logic cpu_ack,
  output logic xfer_ack,
  output logic cpu_done,
  output logic xfer_done,
  output logic [15:0] rdata,
  // external pins
  input wire logic manual_reset_n,
  input wire logic release_request_pin_n,
  input wire logic [15:0] data_in,
  output logic release_grant_n,
  output ext_bus_arb_pkg::pins_s bus_pins
);

  // whole state of the block
  typedef struct packed {
    ext_bus_arb_pkg::phase_e phase; // cycle engine
    ext_bus_arb_pkg::owner_e owner; // acknowledged master
    logic cpu_ack;
    logic xfer_ack;
    logic cpu_done; // one-cycle completion pulses
    logic xfer_done;
    ext_bus_arb_pkg::mreq_s cur; // request being served
    logic last_rd; // previous external cycle was a read
    logic [1:0] last_area; // its area
    logic [15:0] rdata;
    ext_bus_arb_pkg::pins_s pins;
    logic grant_n;
    logic area_change_idle_select;
    logic write_after_read_idle_select;
    logic bus_release_enable;
    logic [15:0] module_stop_control;
    logic expansion_mode;
    logic advanced_mode;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rr_s1; // release request synchroniser
    logic rr_s2;
    logic mr_s1; // manual reset synchroniser
    logic mr_s2;
    logic [15:0] din_s1; // read data synchroniser
    logic [15:0] din_s2;
  } state_s;

  state_s q; // registered state
  state_s d; // next state

  // address decode, shared by error response and write path
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFS_BUS_CTRL_HIGH) || (a == `OFS_BUS_CTRL_LOW) ||
             (a == `OFS_MODULE_STOP) || (a == `OFS_MODE) || (a == `OFS_STATUS);
  endfunction

  // quiet bus: strobes high, data floated, address kept
  function automatic ext_bus_arb_pkg::pins_s quiet(input ext_bus_arb_pkg::pins_s p);
    ext_bus_arb_pkg::pins_s r;
    r = p;
    r.addr_oe_n = 1'b0;
    r.data_oe_n = 1'b1;
    r.cs_n = 4'hF;
    r.address_strobe_n = 1'b1;
    r.rd_n = 1'b1;
    r.upper_write_strobe_n = 1'b1;
    r.lower_write_strobe_n = 1'b1;
    r.ctl_oe_n = 1'b0;
    quiet = r;
  endfunction

  // helper terms
  logic release_halted; // module stop plus sleep kills release
  logic release_ok; // release allowed at all
  logic engine_free; // no external cycle and no pending done
  logic take; // take owner's request this edge
  logic need_idle; // next external cycle starts with idle
  ext_bus_arb_pkg::mreq_s sel; // owner's request
  logic [31:0] rd_val; // apb read value

  // next-state logic
  always_comb begin
    d = q;
    d.cpu_done = 1'b0;
    d.xfer_done = 1'b0;
    rd_val = 32'h0000_0000;

    // pins pass two flip-flops; first stage feeds only the second
    d.rr_s1 = release_request_pin_n;
    d.rr_s2 = q.rr_s1;
    d.mr_s1 = manual_reset_n;
    d.mr_s2 = q.mr_s1;
    d.din_s1 = data_in;
    d.din_s2 = q.din_s1;

    release_halted = cpu_sleep && ((q.module_stop_control == `STOP_ALL_A) ||
                     (q.module_stop_control == `STOP_ALL_B));
    release_ok = q.expansion_mode && q.bus_release_enable && !release_halted;
    engine_free = ((q.phase == ext_bus_arb_pkg::PH_IDLE) ||
                   (q.phase == ext_bus_arb_pkg::PH_RELEASED)) &&
                  !q.cpu_done && !q.xfer_done;

    // arbitration only between bus cycles
    if (engine_free) begin
      case (q.owner)
        ext_bus_arb_pkg::OWN_NONE: begin
          if (xfer_req.req) begin
            d.owner = ext_bus_arb_pkg::OWN_XFER;
          end else if (cpu_req.req) begin
            d.owner = ext_bus_arb_pkg::OWN_CPU;
          end
        end
        ext_bus_arb_pkg::OWN_CPU: begin
          // a longword keeps hold high between its parts
          if (xfer_req.req && (!cpu_req.hold || cpu_sleep)) begin
            d.owner = ext_bus_arb_pkg::OWN_XFER;
          end else if (!cpu_req.req) begin
            d.owner = ext_bus_arb_pkg::OWN_NONE;
          end
        end
        ext_bus_arb_pkg::OWN_XFER: begin
          // hold covers register reads, a transfer and write-back
          if (!xfer_req.hold && !xfer_req.req) begin
            d.owner = cpu_req.req ? ext_bus_arb_pkg::OWN_CPU
                                  : ext_bus_arb_pkg::OWN_NONE;
          end
        end
        default: begin
          d.owner = ext_bus_arb_pkg::OWN_NONE;
        end
      endcase
    end
    d.cpu_ack = (d.owner == ext_bus_arb_pkg::OWN_CPU);
    d.xfer_ack = (d.owner == ext_bus_arb_pkg::OWN_XFER);

    // owner's request; ignored while ownership is moving
    sel = (q.owner == ext_bus_arb_pkg::OWN_XFER) ? xfer_req : cpu_req;
    take = engine_free && (q.owner != ext_bus_arb_pkg::OWN_NONE) && sel.req &&
           (d.owner == q.owner) && q.mr_s2; // no new cycle in manual reset

    // idle decision from the previous external cycle
    need_idle = q.last_rd &&
                ((!sel.wr && q.area_change_idle_select && q.advanced_mode &&
                  (sel.area != q.last_area)) ||
                 (sel.wr && q.write_after_read_idle_select));

    // cycle engine
    case (q.phase)
      ext_bus_arb_pkg::PH_IDLE: begin
        if (!q.rr_s2 && release_ok) begin
          // checked before any new external cycle; engine is between cycles
          d.phase = ext_bus_arb_pkg::PH_RELEASED;
          d.grant_n = 1'b0;
          d.pins.addr_oe_n = 1'b1;
          d.pins.data_oe_n = 1'b1;
          d.pins.ctl_oe_n = 1'b1;
          d.last_rd = 1'b0;
        end else if (take && !sel.ext) begin
          // internal access finishes in one state
          d.cpu_done = (q.owner == ext_bus_arb_pkg::OWN_CPU);
          d.xfer_done = (q.owner == ext_bus_arb_pkg::OWN_XFER);
        end else if (take) begin
          d.cur = sel;
          d.pins = quiet(q.pins);
          d.pins.addr = sel.addr;
          if (need_idle) begin
            d.phase = ext_bus_arb_pkg::PH_GAP;
          end else begin
            d.phase = ext_bus_arb_pkg::PH_T1;
            d.pins.cs_n[sel.area] = 1'b0;
            d.pins.address_strobe_n = 1'b0;
            d.pins.rd_n = sel.wr;
            d.pins.data = sel.wdata;
            d.pins.data_oe_n = !sel.wr;
          end
        end
      end
      ext_bus_arb_pkg::PH_GAP: begin
        // single idle state, then the real cycle
        d.phase = ext_bus_arb_pkg::PH_T1;
        d.pins.cs_n[q.cur.area] = 1'b0;
        d.pins.address_strobe_n = 1'b0;
        d.pins.rd_n = q.cur.wr;
        d.pins.data = q.cur.wdata;
        d.pins.data_oe_n = !q.cur.wr;
      end
      ext_bus_arb_pkg::PH_T1: begin
        // manual reset does not cut the cycle short
        d.phase = ext_bus_arb_pkg::PH_T2;
        d.pins.address_strobe_n = 1'b1;
        d.pins.upper_write_strobe_n = !(q.cur.wr && (q.cur.word || !q.cur.addr[0]));
        d.pins.lower_write_strobe_n = !(q.cur.wr && (q.cur.word || q.cur.addr[0]));
      end
      ext_bus_arb_pkg::PH_T2: begin
        // cycle ends; read data taken, strobes return high
        d.phase = ext_bus_arb_pkg::PH_IDLE;
        d.pins = quiet(q.pins);
        d.last_rd = !q.cur.wr;
        d.last_area = q.cur.area;
        if (!q.cur.wr) begin
          d.rdata = q.din_s2;
        end
        d.cpu_done = (q.owner == ext_bus_arb_pkg::OWN_CPU);
        d.xfer_done = (q.owner == ext_bus_arb_pkg::OWN_XFER);
      end
      ext_bus_arb_pkg::PH_RELEASED: begin
        if (q.rr_s2) begin
          d.phase = ext_bus_arb_pkg::PH_IDLE;
          d.grant_n = 1'b1;
          d.pins = quiet(q.pins);
        end else if (take && !sel.ext) begin
          // internal bus stays usable; external requests just wait
          d.cpu_done = (q.owner == ext_bus_arb_pkg::OWN_CPU);
          d.xfer_done = (q.owner == ext_bus_arb_pkg::OWN_XFER);
        end
      end
      default: begin
        d.phase = ext_bus_arb_pkg::PH_IDLE;
      end
    endcase

    // apb read mux
    case (paddr)
      `OFS_BUS_CTRL_HIGH: begin
        rd_val[`BIT_AREA_CHANGE_IDLE] = q.area_change_idle_select;
        rd_val[`BIT_WRITE_AFTER_READ_IDLE] = q.write_after_read_idle_select;
      end
      `OFS_BUS_CTRL_LOW: begin
        rd_val[`BIT_BUS_RELEASE_ENABLE] = q.bus_release_enable;
      end
      `OFS_MODULE_STOP: begin
        rd_val[15:0] = q.module_stop_control;
      end
      `OFS_MODE: begin
        rd_val[`BIT_EXPANSION_MODE] = q.expansion_mode;
        rd_val[`BIT_ADVANCED_MODE] = q.advanced_mode;
      end
      `OFS_STATUS: begin
        rd_val[`BIT_ST_RELEASED] = (q.phase == ext_bus_arb_pkg::PH_RELEASED);
        rd_val[`BIT_ST_OWNER_LO +: 2] = q.owner;
        rd_val[`BIT_ST_RELEASE_HALTED] = release_halted;
        rd_val[`BIT_ST_MANUAL_RESET] = !q.mr_s2;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase

    // apb: answer prepared in setup, access phase lasts one cycle
    d.pready = psel && !penable;
    d.pslverr = psel && !penable && !mapped(paddr);
    d.prdata = (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;

    // apb write takes effect at the completing edge only
    if (psel && penable && q.pready && pwrite && mapped(paddr)) begin
      case (paddr)
        `OFS_BUS_CTRL_HIGH: begin
          d.area_change_idle_select = pwdata[`BIT_AREA_CHANGE_IDLE];
          d.write_after_read_idle_select = pwdata[`BIT_WRITE_AFTER_READ_IDLE];
        end
        `OFS_BUS_CTRL_LOW: begin
          d.bus_release_enable = pwdata[`BIT_BUS_RELEASE_ENABLE];
        end
        `OFS_MODULE_STOP: begin
          d.module_stop_control = pwdata[15:0];
        end
        `OFS_MODE: begin
          d.expansion_mode = pwdata[`BIT_EXPANSION_MODE];
          d.advanced_mode = pwdata[`BIT_ADVANCED_MODE];
        end
        default: begin
          // status is read only
        end
      endcase
    end
  end

  // state register; power-on reset drops any cycle at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.phase <= ext_bus_arb_pkg::PH_IDLE;
      q.owner <= ext_bus_arb_pkg::OWN_NONE;
      q.pins.addr_oe_n <= 1'b0;
      q.pins.data_oe_n <= 1'b1;
      q.pins.cs_n <= 4'hF;
      q.pins.address_strobe_n <= 1'b1;
      q.pins.rd_n <= 1'b1;
      q.pins.upper_write_strobe_n <= 1'b1;
      q.pins.lower_write_strobe_n <= 1'b1;
      q.grant_n <= 1'b1;
      q.area_change_idle_select <= 1'(`RST_BUS_CTRL_HIGH >> `BIT_AREA_CHANGE_IDLE);
      q.write_after_read_idle_select <= 1'(`RST_BUS_CTRL_HIGH >> `BIT_WRITE_AFTER_READ_IDLE);
      q.bus_release_enable <= `RST_BUS_RELEASE_ENABLE;
      q.module_stop_control <= `RST_MODULE_STOP;
      q.expansion_mode <= 1'(`RST_MODE >> `BIT_EXPANSION_MODE);
      q.advanced_mode <= 1'(`RST_MODE >> `BIT_ADVANCED_MODE);
      q.rr_s1 <= 1'b1;
      q.rr_s2 <= 1'b1;
      q.mr_s1 <= 1'b1;
      q.mr_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign cpu_ack = q.cpu_ack;
  assign xfer_ack = q.xfer_ack;
  assign cpu_done = q.cpu_done;
  assign xfer_done = q.xfer_done;
  assign rdata = q.rdata;
  assign release_grant_n = q.grant_n;
  assign bus_pins = q.pins;

endmodule // ext_bus_arb

// *** ext_bus_arb_asserts.sv ***
// checker: release, ownership and idle pin relations of the arbiter
// assumes: bound onto ext_bus_arb, one clock domain, async reset
module ext_bus_arb_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // masters
  input wire ext_bus_arb_pkg::mreq_s cpu_req,
  input wire logic cpu_ack,
  input wire logic xfer_ack,
  input wire logic cpu_done,
  input wire logic xfer_done,
  // release link and pins
  input wire logic release_request_pin_n,
  input wire logic release_grant_n,
  input wire ext_bus_arb_pkg::pins_s bus_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // grant edges; the pin is seen through two sync flops plus one
  sequence s_grant_on;
    release_grant_n ##1 !release_grant_n;
  endsequence
  sequence s_grant_off;
    !release_grant_n ##1 release_grant_n;
  endsequence
  chk_float_released: assert property (!release_grant_n |->
    bus_pins.addr_oe_n && bus_pins.data_oe_n && bus_pins.ctl_oe_n)
    else $error("bus driven while released");
  chk_grant_follows: assert property (s_grant_on |->
    !$past(release_request_pin_n, 3))
    else $error("grant without request");
  chk_grant_ends: assert property (s_grant_off |->
    $past(release_request_pin_n, 3))
    else $error("grant ended while requested");
  chk_release_boundary: assert property (s_grant_on |->
    $past(bus_pins.rd_n) && $past(&bus_pins.cs_n))
    else $error("release inside a bus cycle");
  chk_ext_waits: assert property (!release_grant_n && cpu_req.ext |-> !cpu_done)
    else $error("external access during release");
  chk_one_owner: assert property (!(cpu_ack && xfer_ack))
    else $error("two owners");
  chk_xfer_owned: assert property (xfer_done |-> $past(xfer_ack))
    else $error("transfer done without ownership");
  chk_cpu_owned: assert property (cpu_done |-> $past(cpu_ack))
    else $error("cpu done without ownership");
  chk_idle_strobes: assert property (cpu_done || xfer_done |-> bus_pins.rd_n &&
    bus_pins.data_oe_n &&
    bus_pins.upper_write_strobe_n && bus_pins.lower_write_strobe_n)
    else $error("strobe low in idle state");
endmodule // ext_bus_arb_asserts

// *** ext_bus_arb_cfg.svh ***
// offsets, field positions, reset values and fixed codes of the arbiter
// assumes: included by bare name wherever these constants are needed
`ifndef EXT_BUS_ARB_CFG_SVH
`define EXT_BUS_ARB_CFG_SVH

// register byte offsets on the apb bus
`define OFS_BUS_CTRL_HIGH 12'h000
`define OFS_BUS_CTRL_LOW 12'h004
`define OFS_MODULE_STOP 12'h008
`define OFS_MODE 12'h00C
`define OFS_STATUS 12'h010

// bus_control_high_register fields
`define BIT_AREA_CHANGE_IDLE 1
`define BIT_WRITE_AFTER_READ_IDLE 0
// bus_control_low_register field
`define BIT_BUS_RELEASE_ENABLE 0
// mode register fields
`define BIT_EXPANSION_MODE 0
`define BIT_ADVANCED_MODE 1
// status register fields
`define BIT_ST_RELEASED 0
`define BIT_ST_OWNER_LO 1
`define BIT_ST_RELEASE_HALTED 3
`define BIT_ST_MANUAL_RESET 4

// reset values
`define RST_BUS_CTRL_HIGH 2'h3
`define RST_BUS_RELEASE_ENABLE 1'h0
`define RST_MODULE_STOP 16'h3FFF
`define RST_MODE 2'h3

// module stop values that halt bus release in sleep
`define STOP_ALL_A 16'hFFFF
`define STOP_ALL_B 16'hEFFF

`endif

// *** ext_bus_arb_pkg.sv ***
// types shared by the external bus arbiter and its surroundings
// assumes: no other package; constants live in ext_bus_arb_cfg.svh
package ext_bus_arb_pkg;

  // bus cycle engine phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_GAP,
    PH_T1,
    PH_T2,
    PH_RELEASED
  } phase_e;

  // current internal bus owner
  typedef enum logic [1:0] {
    OWN_NONE,
    OWN_CPU,
    OWN_XFER
  } owner_e;

  // access request of one internal master
  typedef struct packed {
    logic req; // access wanted, held until done
    logic ext; // external space access
    logic wr; // write when high
    logic word; // word size when high
    logic hold; // more parts follow, bus must not move
    logic [1:0] area; // external area number
    logic [23:0] addr; // byte address
    logic [15:0] wdata; // write data
  } mreq_s;

  // external bus pins, drive values and enables (enable active low)
  typedef struct packed {
    logic [23:0] addr;
    logic addr_oe_n;
    logic [15:0] data;
    logic data_oe_n;
    logic [3:0] cs_n;
    logic address_strobe_n;
    logic rd_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
    logic ctl_oe_n; // enable of cs, strobes
  } pins_s;

endpackage

// *** ext_bus_arb_test.sv ***
// testbench: register defaults, idle insertion, release and priority
// assumes: ext_bus_arb, its package, checker and partner model compiled first
module ext_bus_arb_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_q;
  logic pready, pslverr, cpu_sleep = 0, cpu_ack, xfer_ack, cpu_done, xfer_done;
  logic manual_reset_n = 1, release_request_pin_n, release_grant_n, want = 0, err_q;
  logic [15:0] data_in = '0, rdata;
  ext_bus_arb_pkg::mreq_s cpu_req = '0, xfer_req = '0, r;
  ext_bus_arb_pkg::pins_s bus_pins;
  int n_mismatch = 0, comparisons = 0, seed = 32'hECD1, n, tx, tc, gap;
  // register table and access pattern
  logic [11:0] adr[5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h020};
  logic [31:0] rv[5] = '{32'h3, 32'h0, 32'h3FFF, 32'h3, 32'h0};
  logic [31:0] ms[3] = '{32'hFFFF, 32'hEFFF, 32'h3FFF};
  logic wl[6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
  logic [1:0] al[6] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
  always #5 pclk = ~pclk; // 100 MHz
  ext_bus_arb uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_req, .xfer_req, .cpu_sleep, .cpu_ack,
    .xfer_ack, .cpu_done, .xfer_done, .rdata, .manual_reset_n,
    .release_request_pin_n, .data_in, .release_grant_n, .bus_pins);
  ext_master_model far (.pclk, .presetn, .want, .release_grant_n, .release_request_pin_n);
  task chk(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (e !== s) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled high
  // no cycle count assumed: only the watchdog ends a wait for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // wait for cpu done, checking data while the upper write strobe is low
  // gap counts quiet cycles that already show the new address
  task wait_done(input logic [15:0] wd, input logic [23:0] wa, input logic [1:0] ar);
    n = 0;
    gap = 0;
    do begin
      @(posedge pclk);
      n++;
      if (bus_pins.upper_write_strobe_n === 1'b0) chk("wdata", wd, bus_pins.data);
      if (bus_pins.address_strobe_n === 1'b0) chk("addr", wa, bus_pins.addr);
      if (bus_pins.address_strobe_n === 1'b0) chk("cs", 4'(~(4'h1 << ar)), bus_pins.cs_n);
      if ({&bus_pins.cs_n, bus_pins.data_oe_n, bus_pins.rd_n} === 3'h7 &&
          bus_pins.addr === wa) begin
        gap++;
      end
    end while (cpu_done !== 1'b1 && n < 60);
    chk("done", 1, cpu_done);
  endtask
  // back to back cpu accesses; the model predicts idle insertion
  task run_chain(input logic [1:0] bch, md);
    logic lr, id;
    logic [1:0] la;
    lr = 0;
    la = 0;
    apb(1, 12'h000, {30'h0, bch});
    apb(1, 12'h00C, {30'h0, md});
    data_in <= 16'($random(seed));
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      r = '0; r.req = 1; r.ext = 1; r.word = 1; r.wr = wl[i]; r.area = al[i];
      r.addr = 24'($random(seed)) & 24'hFFFFFE;
      r.wdata = 16'($random(seed));
      cpu_req <= r;
      id = lr && (r.wr ? bch[0] : (al[i] != la && bch[1] && md[1]));
      wait_done(r.wdata, r.addr, r.area);
      if (i > 0) chk("latency", 4 + id, n);
      if (i > 0) chk("idle_addr", 1 + id, gap);
      if (!r.wr) chk("rdata", data_in, rdata);
      lr = !r.wr;
      la = al[i];
    end
    cpu_req <= '0;
  endtask
  // both masters ask at once; first done cycle of each is recorded
  task pair(input logic e);
    @(posedge pclk);
    tx = 99; tc = 99;
    r = '0; r.req = 1; r.ext = e; r.word = 1; r.addr = 24'h000100;
    cpu_req <= r;
    r.ext = 0;
    xfer_req <= r;
    for (int k = 0; k < 30; k++) begin
      @(posedge pclk);
      if (xfer_done === 1'b1 && tx == 99) begin tx = k; xfer_req <= '0; end
      if (cpu_done === 1'b1 && tc == 99) begin tc = k; cpu_req <= '0; end
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 5; i++) begin
      apb(0, adr[i], 32'h0);
      chk("reg", rv[i], rd_q);
      chk("slverr", i == 4, err_q);
    end
    run_chain(2'h3, 2'h3);
    run_chain(2'h0, 2'h3);
    run_chain(2'h3, 2'h1);
    pair(0);
    chk("xfer_first", 1, tx < tc);
    // a held cpu keeps the bus; sleep hands it over; a held transfer keeps it
    r = '0;
    r.req = 1;
    r.hold = 1;
    cpu_req <= r;
    wait_done(16'h0, 24'h0, 2'h0);
    xfer_req <= r;
    repeat (10) @(posedge pclk);
    chk("cpu_keeps", 1, cpu_ack);
    cpu_sleep <= 1;
    repeat (4) @(posedge pclk);
    chk("sleep_yields", 1, xfer_ack);
    cpu_sleep <= 0;
    r.req = 0;
    xfer_req <= r;
    repeat (4) @(posedge pclk);
    chk("xfer_keeps", 1, xfer_ack);
    xfer_req <= '0;
    cpu_req <= '0;
    want <= 1;
    repeat (8) @(posedge pclk);
    chk("grant_off", 1, release_grant_n);
    apb(1, 12'h004, 32'h1);
    repeat (5) @(posedge pclk);
    chk("grant_on", 0, release_grant_n);
    apb(0, 12'h010, 32'h0);
    chk("status", 32'h1, rd_q);
    pair(1);
    chk("internal_runs", 1, tx < 30);
    chk("ext_held", 99, tc);
    want <= 0;
    wait_done(16'h0, 24'h000100, 2'h0);
    chk("grant_back", 1, release_grant_n);
    chk("ext_resumes", 1, cpu_done);
    cpu_req <= '0;
    cpu_sleep <= 1;
    for (int i = 0; i < 3; i++) begin
      apb(1, 12'h008, ms[i]);
      want <= 1;
      repeat (8) @(posedge pclk);
      chk("sleep_grant", i != 2, release_grant_n);
      want <= 0;
      repeat (8) @(posedge pclk);
    end
    cpu_sleep <= 0;
    // manual reset lands inside an external read: it ends, no new one starts
    r = '0;
    r.req = 1;
    r.ext = 1;
    r.word = 1;
    r.addr = 24'h000200;
    cpu_req <= r;
    manual_reset_n <= 0;
    wait_done(16'h0, r.addr, 2'h0);
    r.addr = 24'h000300;
    cpu_req <= r;
    tc = 0;
    repeat (8) begin
      @(posedge pclk);
      if (cpu_done !== 1'b0) tc++;
    end
    chk("mr_blocks", 0, tc);
    manual_reset_n <= 1;
    wait_done(16'h0, r.addr, 2'h0);
    cpu_req <= '0;
    apb(0, 12'h004, 32'h0);
    chk("kept", 1, rd_q);
    final_report;
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    final_report;
  end
endmodule // ext_bus_arb_test
bind ext_bus_arb ext_bus_arb_asserts chk_i (.pclk, .presetn, .cpu_req, .cpu_ack,
  .xfer_ack, .cpu_done, .xfer_done, .release_request_pin_n, .release_grant_n, .bus_pins);

// *** ext_master_model.sv ***
// partner: outside master asking for the external bus
// assumes: pclk domain, active low request and grant pins
module ext_master_model #(
  parameter int HOLD = 2 // least tenure once granted
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench command and arbiter answer
  input wire logic want,
  input wire logic release_grant_n,
  // request pin
  output logic release_request_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int held; // cycles spent owning the bus
  // request follows want; a granted tenure lasts at least HOLD cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_request_pin_n <= 1'b1;
      held <= 0;
    end else begin
      held <= release_grant_n ? 0 : held + 1;
      if (want) release_request_pin_n <= 1'b0;
      else if (release_grant_n || held >= HOLD) release_request_pin_n <= 1'b1;
    end
  end
endmodule // ext_master_model
